//--- design/reset_startup_sequencer.sv
// Reset and start-up sequencer: classifies reset causes, keeps the status
// flags, runs the power-up delay and oscillator start-up count.
// Assumes events from the core are single-cycle pulses on mclk; supply and
// pin inputs are asynchronous and synchronised here.
//
// Contract
// R1: Distinguish power-on, master clear running/asleep, watchdog running/asleep.
// R2: Never-reset registers get no reset strobe at all.
// R3: Defined-reset strobe for all causes except watchdog during sleep; the code also gives none on interrupt wake.
// R4: Power-on gives cause bit 0, expired and powerdown flags 1.
// R5: Watchdog clears expired flag; powerdown 1 running, 0 from sleep.
// R6: Master clear running sets all 1; sleep clear or wake clears powerdown.
// R7: Supply below trip over about one microsecond clears low-supply flag.
// R8: Firmware polls the low-supply flag.
// R9: Supply rise makes a power-on pulse; a fall makes none.
// R10: Power-up delay of 72 ms only after power-on.
// R11: Power-up delay counts a local free-running tick, not the core clock.
// R12: Delay fuse 1 disables the power-up delay, 0 enables it.
// R13: Crystal mode holds reset 1024 clock-pin cycles after the delay.
// R14: Internal oscillator adds only eight cycles after power-on or wake.
// R15: Power-up delay first, then start-up count in crystal mode.
// R16: Internal oscillator with delay fused off adds no time-out.
// R17: Clock-source fuse 0 selects crystal, 1 internal oscillator.
// R18: Master clear low holds reset; release after all enabled stages.
`timescale 1ns/10ps

module reset_startup_sequencer #(
    parameter int POWERUP_CYCLES = rst_seq_pkg::POWERUP_DELAY_CYCLES,
    parameter int CRYSTAL_EDGES = rst_seq_pkg::CRYSTAL_STARTUP_EDGES
) (
    input wire logic mclk,
    input wire logic rst,
    // Pins and analog comparators (asynchronous)
    input wire logic external_master_reset_n,
    input wire logic supply_rise,
    input wire logic supply_low,
    input wire logic osc_pin,
    input wire logic local_osc_tick,
    // Fuses
    input wire logic powerup_delay_fuse,
    input wire logic clock_source_fuse,
    // Core events (same clock)
    input wire logic watchdog,
    input wire logic sleeping,
    input wire logic deep_sleep_state,
    input wire logic irq_wake,
    // Outputs
    output logic core_reset,
    output logic defined_reset,
    output logic resume,
    output rst_seq_pkg::cause_flags_type cause_flags,
    output logic low_supply_flag,
    output logic irq,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ------------------------------------------------------------------
    // Input synchronisers: three stages, change counts when 2 and 3 agree
    // ------------------------------------------------------------------
    localparam int NSYNC = 5;
    wire [NSYNC-1:0] async_in = {local_osc_tick, osc_pin, supply_low, supply_rise,
                                 external_master_reset_n};
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic [NSYNC-1:0] sync_c;
    logic [NSYNC-1:0] clean;
    logic [NSYNC-1:0] clean_d;

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                    sync_c[gi] <= 1'b0;
                    clean[gi] <= 1'b0;
                    clean_d[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= async_in[gi];
                    sync_b[gi] <= sync_a[gi];
                    sync_c[gi] <= sync_b[gi];
                    clean_d[gi] <= clean[gi];
                    if (sync_b[gi] == sync_c[gi]) begin
                        clean[gi] <= sync_c[gi];
                    end
                end
            end
        end
    endgenerate

    wire pin_held = ~clean[0]; // R18
    wire rise_pulse = clean[1] & ~clean_d[1]; // R9
    wire low_level = clean[2];
    wire osc_edge = clean[3] & ~clean_d[3];
    wire tick_edge = clean[4] & ~clean_d[4]; // R11
    wire crystal_mode = ~clock_source_fuse; // R17
    wire delay_enabled = ~powerup_delay_fuse; // R12

    // ------------------------------------------------------------------
    // Cause decode
    // ------------------------------------------------------------------
    wire asleep = sleeping | deep_sleep_state;
    wire pin_fall = pin_held & clean_d[0];
    rst_seq_pkg::cause_type cause;
    assign cause = rise_pulse ? rst_seq_pkg::CAUSE_POWERON :
                   (pin_fall & asleep) ? rst_seq_pkg::CAUSE_PIN_SLEEP :
                   pin_fall ? rst_seq_pkg::CAUSE_PIN_RUN :
                   (watchdog & asleep) ? rst_seq_pkg::CAUSE_WD_SLEEP :
                   watchdog ? rst_seq_pkg::CAUSE_WD_RUN :
                   (irq_wake & asleep) ? rst_seq_pkg::CAUSE_IRQ_WAKE :
                   rst_seq_pkg::CAUSE_NONE; // R1

    wire is_por = cause == rst_seq_pkg::CAUSE_POWERON;
    wire is_wake = (cause == rst_seq_pkg::CAUSE_WD_SLEEP) |
                   (cause == rst_seq_pkg::CAUSE_IRQ_WAKE);
    // Watchdog during sleep resumes; the never-reset class is simply not
    // wired to any strobe from this block
    wire defines_regs = (cause != rst_seq_pkg::CAUSE_NONE) & ~is_wake; // R3 R2

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    rst_seq_pkg::cause_flags_type next_flags;
    always_comb begin
        next_flags = cause_flags;
        unique case (cause)
            rst_seq_pkg::CAUSE_POWERON: next_flags = 3'h3; // R4
            rst_seq_pkg::CAUSE_PIN_RUN: next_flags = 3'h7; // R6
            rst_seq_pkg::CAUSE_PIN_SLEEP,
            rst_seq_pkg::CAUSE_IRQ_WAKE: next_flags = 3'h6; // R6
            rst_seq_pkg::CAUSE_WD_RUN: next_flags = 3'h5; // R5
            rst_seq_pkg::CAUSE_WD_SLEEP: next_flags = 3'h4; // R5
            default: next_flags = cause_flags;
        endcase
    end

    // Firmware sets cause bit to 1 after reading a power-on (write to reg)
    logic sw_set_poweron;
    rst_seq_pkg::cause_flags_type flags_w;
    assign flags_w = sw_set_poweron ? {1'b1, next_flags[1:0]} : next_flags;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cause_flags <= rst_seq_pkg::CAUSE_RESET;
        end else begin
            cause_flags <= (cause != rst_seq_pkg::CAUSE_NONE) ? next_flags : flags_w;
        end
    end

    // ------------------------------------------------------------------
    // Low-supply detector
    // ------------------------------------------------------------------
    localparam int LOW_CYC = rst_seq_pkg::LOW_SUPPLY_CYCLES;
    logic [$clog2(LOW_CYC+1)-1:0] low_count;
    wire low_trip = low_level && (low_count == ($clog2(LOW_CYC+1))'(LOW_CYC));
    logic sw_set_low;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            low_count <= '0;
            low_supply_flag <= 1'b1;
        end else begin
            if (!low_level) begin
                low_count <= '0;
            end else if (!low_trip) begin
                low_count <= low_count + 1'b1;
            end
            // Clear from the detector wins over software re-arm
            if (low_trip) begin
                low_supply_flag <= 1'b0; // R7 R8
            end else if (sw_set_low) begin
                low_supply_flag <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Time-out sequence
    // ------------------------------------------------------------------
    localparam int PW = $clog2(POWERUP_CYCLES + 1);
    localparam int SW = $clog2(CRYSTAL_EDGES + 1);
    rst_seq_pkg::seq_state_type state;
    logic [PW-1:0] pu_count;
    logic [SW-1:0] st_count;
    logic startup_due;

    // Local oscillator advances the power-up count; it is modelled as a
    // tick pin so the delay is independent of the core clock choice
    wire pu_done = pu_count >= PW'(POWERUP_CYCLES);
    wire [SW-1:0] st_goal = crystal_mode ? SW'(CRYSTAL_EDGES) :
                            SW'(rst_seq_pkg::INTERNAL_STARTUP_CYCLES);
    wire st_done = st_count >= st_goal;
    wire st_step = crystal_mode ? osc_edge : 1'b1; // R13 R14

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= rst_seq_pkg::ST_HOLD;
            pu_count <= '0;
            st_count <= '0;
            startup_due <= 1'b0;
        end else if (pin_held || is_por) begin
            state <= rst_seq_pkg::ST_HOLD; // R18
            pu_count <= '0;
            st_count <= '0;
            startup_due <= is_por | startup_due;
        end else begin
            unique case (state)
                rst_seq_pkg::ST_HOLD: begin
                    if (startup_due && delay_enabled) begin
                        state <= rst_seq_pkg::ST_POWERUP; // R10 R15
                    end else if (startup_due && crystal_mode) begin
                        state <= rst_seq_pkg::ST_STARTUP;
                    end else begin
                        // No power-on pending, or internal oscillator with delay fused off: no time-out
                        state <= rst_seq_pkg::ST_RUN; // R10 R16
                        startup_due <= 1'b0;
                    end
                end
                rst_seq_pkg::ST_POWERUP: begin
                    if (pu_done) begin
                        state <= rst_seq_pkg::ST_STARTUP; // R15
                    end else if (tick_edge) begin
                        pu_count <= pu_count + 1'b1; // R11
                    end
                end
                rst_seq_pkg::ST_STARTUP: begin
                    if (st_done) begin
                        state <= rst_seq_pkg::ST_RUN; // R13
                        startup_due <= 1'b0;
                    end else if (st_step) begin
                        st_count <= st_count + 1'b1;
                    end
                end
                rst_seq_pkg::ST_RUN: begin
                    // Internal-oscillator wake gets the short start-up count
                    if (is_wake && !crystal_mode) begin
                        state <= rst_seq_pkg::ST_STARTUP; // R14
                        st_count <= '0;
                    end
                end
                default: state <= rst_seq_pkg::ST_HOLD;
            endcase
        end
    end

    assign core_reset = state != rst_seq_pkg::ST_RUN; // R18

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            defined_reset <= 1'b0;
            resume <= 1'b0;
        end else begin
            defined_reset <= defines_regs; // R3
            resume <= is_wake;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    logic [rst_seq_pkg::IRQ_WIDTH-1:0] irq_status;
    logic [rst_seq_pkg::IRQ_WIDTH-1:0] irq_mask;
    logic [rst_seq_pkg::IRQ_WIDTH-1:0] irq_clear;
    logic core_reset_d;
    wire [rst_seq_pkg::IRQ_WIDTH-1:0] irq_event = {low_trip & low_supply_flag,
                                                  core_reset_d & ~core_reset};
    assign irq = |(irq_status & irq_mask);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_status <= '0;
            core_reset_d <= 1'b1;
        end else begin
            core_reset_d <= core_reset;
            // Set beats clear in the same cycle
            irq_status <= (irq_status & ~irq_clear) | irq_event;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held & ~s_axi_bvalid;
    wire do_write = aw_held & w_held & ~s_axi_bvalid;
    wire wr_lane0 = do_write & w_strb[0];
    wire wr_hit = (aw_addr == rst_seq_pkg::OFS_CAUSE) |
                  (aw_addr == rst_seq_pkg::OFS_POWER_CONTROL) |
                  (aw_addr == rst_seq_pkg::OFS_IRQ_STATUS) |
                  (aw_addr == rst_seq_pkg::OFS_IRQ_MASK) |
                  (aw_addr == rst_seq_pkg::OFS_SEQ_STATE);
    assign sw_set_poweron = wr_lane0 & (aw_addr == rst_seq_pkg::OFS_CAUSE) &
                            w_data[rst_seq_pkg::BIT_POWERON_CAUSE];
    assign sw_set_low = wr_lane0 & (aw_addr == rst_seq_pkg::OFS_POWER_CONTROL) &
                        w_data[rst_seq_pkg::BIT_LOW_SUPPLY];
    assign irq_clear = (wr_lane0 && aw_addr == rst_seq_pkg::OFS_IRQ_STATUS) ?
                       w_data[rst_seq_pkg::IRQ_WIDTH-1:0] : '0;
    wire mask_write = wr_lane0 & (aw_addr == rst_seq_pkg::OFS_IRQ_MASK);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rst_seq_pkg::RESP_OKAY;
            irq_mask <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (mask_write) begin
                irq_mask <= w_data[rst_seq_pkg::IRQ_WIDTH-1:0];
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? rst_seq_pkg::RESP_OKAY : rst_seq_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic [31:0] rd_value;
    logic rd_hit;
    always_comb begin
        rd_value = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            rst_seq_pkg::OFS_CAUSE: rd_value[2:0] = cause_flags;
            rst_seq_pkg::OFS_POWER_CONTROL: begin
                rd_value[rst_seq_pkg::BIT_LOW_SUPPLY] = low_supply_flag;
                rd_value[rst_seq_pkg::BIT_POWERON_N] = cause_flags.poweron_n;
            end
            rst_seq_pkg::OFS_IRQ_STATUS: rd_value[rst_seq_pkg::IRQ_WIDTH-1:0] = irq_status;
            rst_seq_pkg::OFS_IRQ_MASK: rd_value[rst_seq_pkg::IRQ_WIDTH-1:0] = irq_mask;
            rst_seq_pkg::OFS_SEQ_STATE: rd_value[2:0] = state;
            default: rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = ~s_axi_rvalid;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= rst_seq_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= rd_hit ? rst_seq_pkg::RESP_OKAY : rst_seq_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

//--- design/rst_seq_pkg.sv
// Shared constants and carrier types for the reset and start-up sequencer.
// Assumes a single 125 MHz clock domain and an AXI4-Lite register master.
package rst_seq_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int POWERUP_DELAY_MS = 72;
    localparam int POWERUP_DELAY_CYCLES = POWERUP_DELAY_MS * 1000 * CLK_MHZ;
    localparam int LOW_SUPPLY_NS = 1000;
    localparam int LOW_SUPPLY_CYCLES = (LOW_SUPPLY_NS * CLK_MHZ) / 1000;
    localparam int CRYSTAL_STARTUP_EDGES = 1024;
    localparam int INTERNAL_STARTUP_CYCLES = 8;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CAUSE = 8'h00;
    localparam logic [7:0] OFS_POWER_CONTROL = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFS_SEQ_STATE = 8'h10;

    // Cause register fields
    localparam int BIT_POWERDOWN = 0;
    localparam int BIT_WATCHDOG_EXPIRED = 1;
    localparam int BIT_POWERON_CAUSE = 2;
    // Power control register fields
    localparam int BIT_LOW_SUPPLY = 0;
    localparam int BIT_POWERON_N = 1;
    // Interrupt event bits
    localparam int IRQ_RESET_DONE = 0;
    localparam int IRQ_LOW_SUPPLY = 1;
    localparam int IRQ_WIDTH = 2;

    localparam logic [2:0] CAUSE_RESET = 3'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Decoded reset cause
    typedef enum logic [2:0] {
        CAUSE_NONE = 3'h0,
        CAUSE_POWERON = 3'h1,
        CAUSE_PIN_RUN = 3'h2,
        CAUSE_PIN_SLEEP = 3'h3,
        CAUSE_WD_RUN = 3'h4,
        CAUSE_WD_SLEEP = 3'h5,
        CAUSE_IRQ_WAKE = 3'h6
    } cause_type;

    // Sequencer states, Gray along the power-up path
    typedef enum logic [2:0] {
        ST_HOLD = 3'b000,
        ST_POWERUP = 3'b001,
        ST_STARTUP = 3'b011,
        ST_RUN = 3'b010
    } seq_state_type;

    // Status flags seen by the core
    typedef struct packed {
        logic poweron_n;
        logic watchdog_expired_flag;
        logic powerdown_flag;
    } cause_flags_type;

endpackage

//--- tb/board_reset_source.sv
// Board-side master clear source: a push button on a pulled-up pin.
// Assumes press is driven by the bench just after the mclk edge.
`timescale 1ns/10ps
module board_reset_source (
    input wire logic mclk,
    input wire logic press,
    output logic external_master_reset_n
);
    // Pull-up holds the pin high whenever the button is open
    assign external_master_reset_n = !press;
endmodule

//--- tb/reset_startup_sequencer_tb_top.sv
// Self-checking bench for the reset and start-up sequencer.
// Assumes short delay parameters; the bench plays supply, oscillators and core.
`timescale 1ns/10ps
module reset_startup_sequencer_tb_top;
    // ----------------------------------------------------------------
    // Stimulus, instances and scenarios
    // ----------------------------------------------------------------
    localparam int PU = 20;
    localparam int XE = 16;
    logic mclk = 1'b0, rst = 1'b1, press = 1'b0, supply_rise = 1'b0, supply_low = 1'b0;
    logic osc_pin = 1'b0, local_osc_tick = 1'b0, delay_fuse = 1'b0, src_fuse = 1'b0;
    logic watchdog = 1'b0, sleeping = 1'b0, deep_sleep_state = 1'b0, irq_wake = 1'b0;
    logic ext_n, core_reset, defined_reset, resume, low_supply_flag, irq;
    rst_seq_pkg::cause_flags_type cause_flags;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int err_total = 0, tests_run = 0, cycles = 0;

    always #4 mclk = ~mclk;

    board_reset_source board_u (.mclk(mclk), .press(press), .external_master_reset_n(ext_n));
    reset_startup_sequencer #(.POWERUP_CYCLES(PU), .CRYSTAL_EDGES(XE)) dut_u (
        .mclk(mclk), .rst(rst), .external_master_reset_n(ext_n), .supply_rise(supply_rise),
        .supply_low(supply_low), .osc_pin(osc_pin), .local_osc_tick(local_osc_tick),
        .powerup_delay_fuse(delay_fuse), .clock_source_fuse(src_fuse), .watchdog(watchdog),
        .sleeping(sleeping), .deep_sleep_state(deep_sleep_state), .irq_wake(irq_wake),
        .core_reset(core_reset), .defined_reset(defined_reset), .resume(resume),
        .cause_flags(cause_flags), .low_supply_flag(low_supply_flag), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    task automatic finish_test();
        $display("errors %0d checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Pulses wide enough to cross the input synchronisers
    task automatic pulse(input int n, input bit osc);
        repeat (n) begin
            if (osc) osc_pin <= 1'b1;
            else local_osc_tick <= 1'b1;
            tick(4);
            osc_pin <= 1'b0;
            local_osc_tick <= 1'b0;
            tick(4);
        end
    endtask

    task automatic wait_free(input int lim);
        int n = 0;
        while (core_reset !== 1'b0 && n < lim) begin
            tick(1);
            n++;
        end
        chk(core_reset, 1'b0);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            tick(1);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        chk(bresp, rst_seq_pkg::RESP_OKAY);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            tick(1);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        chk(rdata, e);
        chk(rresp, r);
    endtask

    task automatic power_on();
        supply_rise <= 1'b1;
        tick(6);
        supply_rise <= 1'b0;
        tick(4);
    endtask

    task automatic clear_pin(input logic [2:0] e);
        press <= 1'b1;
        tick(10);
        chk(core_reset, 1'b1);
        chk(cause_flags, e);
        press <= 1'b0;
        wait_free(20);
    endtask

    task automatic core_pulse(input bit wake, input logic [2:0] e);
        if (wake) irq_wake <= 1'b1;
        else watchdog <= 1'b1;
        tick(1);
        irq_wake <= 1'b0;
        watchdog <= 1'b0;
        tick(3);
        chk(cause_flags, e);
        chk(core_reset, sleeping);
        wait_free(20);
    endtask

    initial begin
        tick(5);
        rst <= 1'b0;
        tick(8);
        power_on();
        chk(cause_flags, 3'h3);
        pulse(PU - 1, 1'b0);
        chk(core_reset, 1'b1);
        pulse(1, 1'b0);
        tick(8);
        pulse(XE - 1, 1'b1);
        chk(core_reset, 1'b1);
        pulse(1, 1'b1);
        wait_free(20);
        axi_rd(rst_seq_pkg::OFS_CAUSE, 32'h3, rst_seq_pkg::RESP_OKAY);
        axi_wr(rst_seq_pkg::OFS_CAUSE, 32'h4);
        chk(cause_flags, 3'h7);
        axi_rd(8'h40, 32'h0, rst_seq_pkg::RESP_SLVERR);
        axi_wr(rst_seq_pkg::OFS_IRQ_MASK, 32'h0);
        chk(irq, 1'b0);
        axi_wr(rst_seq_pkg::OFS_IRQ_MASK, 32'h3);
        chk(irq, 1'b1);
        axi_wr(rst_seq_pkg::OFS_IRQ_STATUS, 32'h1);
        chk(irq, 1'b0);
        delay_fuse <= 1'b1;
        src_fuse <= 1'b1;
        power_on();
        wait_free(30);
        clear_pin(3'h7);
        core_pulse(1'b0, 3'h5);
        deep_sleep_state <= 1'b1;
        clear_pin(3'h6);
        deep_sleep_state <= 1'b0;
        sleeping <= 1'b1;
        core_pulse(1'b0, 3'h4);
        core_pulse(1'b1, 3'h6);
        sleeping <= 1'b0;
        supply_low <= 1'b1;
        tick(60);
        chk(low_supply_flag, 1'b1);
        tick(100);
        chk(low_supply_flag, 1'b0);
        supply_low <= 1'b0;
        tick(6);
        axi_wr(rst_seq_pkg::OFS_POWER_CONTROL, 32'h1);
        chk(low_supply_flag, 1'b1);
        chk(irq, 1'b1);
        finish_test();
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            finish_test();
        end
    end
endmodule

//--- tb/rst_seq_sva.sv
// Port checker for the reset and start-up sequencer.
// Assumes it is bound onto reset_startup_sequencer and sees its ports only.
`timescale 1ns/10ps
module rst_seq_sva #(
    parameter int POWERUP_CYCLES = 20,
    parameter int CRYSTAL_EDGES = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic external_master_reset_n,
    input wire logic supply_rise,
    input wire logic supply_low,
    input wire logic watchdog,
    input wire logic sleeping,
    input wire logic deep_sleep_state,
    input wire logic irq_wake,
    input wire logic core_reset,
    input wire logic defined_reset,
    input wire logic resume,
    input wire rst_seq_pkg::cause_flags_type cause_flags,
    input wire logic low_supply_flag
);
    // ----------------------------------------------------------------
    // Helper logic and properties
    // ----------------------------------------------------------------
    logic [7:0] low_cnt;
    logic asleep;
    assign asleep = sleeping || deep_sleep_state;
    // Saturates so a long brown-out never wraps back to a short one
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) low_cnt <= 8'h00;
        else if (!supply_low) low_cnt <= 8'h00;
        else if (low_cnt != 8'hff) low_cnt <= low_cnt + 8'h01;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_por_flags: assert property ($rose(supply_rise) |-> ##[1:8]
        (core_reset && cause_flags == 3'h3)) else $error("power-on flags wrong");
    a_pin_hold: assert property ((!external_master_reset_n)[*6] |-> core_reset)
        else $error("core ran with master clear low");
    a_pin_run: assert property ($fell(external_master_reset_n) && !asleep && !core_reset
        |-> ##[2:8] cause_flags == 3'h7) else $error("running clear flags wrong");
    a_pin_sleep: assert property ($fell(external_master_reset_n) && asleep && !core_reset
        |-> ##[2:8] cause_flags == 3'h6) else $error("sleep clear flags wrong");
    a_wd_run: assert property (watchdog && !asleep && !core_reset && external_master_reset_n
        |=> cause_flags == 3'h5 && defined_reset) else $error("watchdog run wrong");
    a_wd_sleep: assert property (watchdog && asleep && external_master_reset_n
        |=> cause_flags == 3'h4 && resume && !defined_reset) else $error("watchdog wake wrong");
    a_wake_pd: assert property (irq_wake && asleep && !watchdog && external_master_reset_n
        |=> !cause_flags.powerdown_flag && resume) else $error("interrupt wake wrong");
    a_low_clear: assert property (low_cnt == 8'h8c |-> !low_supply_flag)
        else $error("low supply flag not cleared");
    a_low_short: assert property ($fell(low_supply_flag) |-> low_cnt > 8'h64)
        else $error("low supply flag cleared too soon");
endmodule
bind reset_startup_sequencer rst_seq_sva #(.POWERUP_CYCLES(POWERUP_CYCLES),
    .CRYSTAL_EDGES(CRYSTAL_EDGES)) sva_u (.mclk(mclk), .rst(rst),
    .external_master_reset_n(external_master_reset_n), .supply_rise(supply_rise),
    .supply_low(supply_low), .watchdog(watchdog), .sleeping(sleeping),
    .deep_sleep_state(deep_sleep_state), .irq_wake(irq_wake), .core_reset(core_reset),
    .defined_reset(defined_reset), .resume(resume), .cause_flags(cause_flags),
    .low_supply_flag(low_supply_flag));
